// ### dpsl_port_ctrl.sv
// Controller for one port of a dual-port semaphore unit
//
// Notes on behaviour
// - Flags are active low; write zero to request, one to release.
// - Between polling reads select or output enable must go high.
// - Request by writing zero, then read back; zero means granted.
// - After failure keep reading or write one to withdraw.
// - At start each port writes one to all eight flags.
`timescale 1ns/100ps
`default_nettype none
module dpsl_port_ctrl
    import dpsl_pkg::*;
#(
    parameter int POLL_LIMIT = POLL_MAX
)
(
    input  wire logic                clock_i,
    input  wire logic                rst_i,
    input  wire logic                cmd_valid_i,
    input  wire dpsl_op_type         cmd_op_i,
    input  wire logic [INDEX_W-1:0]  cmd_index_i,
    input  wire logic [DATA_W-1:0]   data_i,
    output logic                     ready_o,
    output logic                     done_o,
    output logic                     granted_o,
    output logic                     flag_o,
    output var dpsl_pins_type        pins_o
);

    if (POLL_LIMIT < 0 || POLL_LIMIT > 255) begin : g_chk
        $error("POLL_LIMIT must lie in 0..255");
    end

    typedef enum logic [6:0] {
        PS_IDLE     = 7'h01,
        PS_INIT_WR  = 7'h02,
        PS_ACQ_WR   = 7'h04,
        PS_ACQ_RD   = 7'h08,
        PS_WITHDRAW = 7'h10,
        PS_REL_WR   = 7'h20,
        PS_READ     = 7'h40
    } dpsl_ps_type;

    // ------------------------------------------------------------
    // Pin access engine
    // ------------------------------------------------------------
    logic               cyc_start, cyc_write, cyc_wbit;
    logic               cyc_done, cyc_rbit;
    logic [INDEX_W-1:0] idx_r, idx_nxt;

    dpsl_pin_cycle u_cycle (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .start_i (cyc_start),
        .write_i (cyc_write),
        .index_i (idx_r),
        .wbit_i  (cyc_wbit),
        .data_i  (data_i),
        .done_o  (cyc_done),
        .rbit_o  (cyc_rbit),
        .pins_o  (pins_o)
    );

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    dpsl_ps_type st_r, st_nxt;
    logic        wait_r, wait_nxt;
    logic [7:0]  poll_r, poll_nxt;
    logic        ready_r, ready_nxt;
    logic        done_r, done_nxt;
    logic        grant_r, grant_nxt;
    logic        flag_r, flag_nxt;

    always_comb begin
        st_nxt    = st_r;
        idx_nxt   = idx_r;
        wait_nxt  = wait_r;
        poll_nxt  = poll_r;
        grant_nxt = grant_r;
        flag_nxt  = flag_r;
        done_nxt  = 1'h0;
        cyc_start = 1'h0;
        cyc_write = 1'h1;
        cyc_wbit  = FLAG_FREE;
        // One access at a time; wait_r marks it in flight
        if (st_r != PS_IDLE && !wait_r) begin
            cyc_start = 1'h1;
            wait_nxt  = 1'h1;
        end
        if (cyc_done) begin
            wait_nxt = 1'h0;
        end
        case (st_r)
            PS_IDLE: begin
                if (cmd_valid_i) begin
                    idx_nxt  = cmd_index_i;
                    poll_nxt = 8'h00;
                    case (cmd_op_i)
                        DPSL_OP_INIT: begin
                            idx_nxt = 3'h0;
                            st_nxt  = PS_INIT_WR;
                        end
                        DPSL_OP_ACQUIRE: st_nxt = PS_ACQ_WR;
                        DPSL_OP_RELEASE: st_nxt = PS_REL_WR;
                        default:         st_nxt = PS_READ;
                    endcase
                end
            end
            PS_INIT_WR: begin
                // Free every flag from this side at start-up
                cyc_wbit = FLAG_FREE;
                if (cyc_done) begin
                    if (idx_r == INDEX_LAST) begin
                        grant_nxt = 1'h0;
                        done_nxt  = 1'h1;
                        st_nxt    = PS_IDLE;
                    end else begin
                        idx_nxt = idx_r + 3'h1;
                    end
                end
            end
            PS_ACQ_WR: begin
                cyc_wbit = FLAG_TAKE;
                if (cyc_done) begin
                    st_nxt = PS_ACQ_RD;
                end
            end
            PS_ACQ_RD: begin
                cyc_write = 1'h0;
                if (cyc_done) begin
                    flag_nxt = cyc_rbit;
                    if (cyc_rbit == FLAG_TAKE) begin
                        grant_nxt = 1'h1;
                        done_nxt  = 1'h1;
                        st_nxt    = PS_IDLE;
                    end else if (poll_r < 8'(POLL_LIMIT)) begin
                        // Recovery gap in each access re-arms the latch
                        poll_nxt = poll_r + 8'h01;
                    end else begin
                        st_nxt = PS_WITHDRAW;
                    end
                end
            end
            PS_WITHDRAW: begin
                // Leaving a pending zero would hang the far side
                cyc_wbit = FLAG_FREE;
                if (cyc_done) begin
                    grant_nxt = 1'h0;
                    done_nxt  = 1'h1;
                    st_nxt    = PS_IDLE;
                end
            end
            PS_REL_WR: begin
                cyc_wbit = FLAG_FREE;
                if (cyc_done) begin
                    grant_nxt = 1'h0;
                    done_nxt  = 1'h1;
                    st_nxt    = PS_IDLE;
                end
            end
            PS_READ: begin
                cyc_write = 1'h0;
                if (cyc_done) begin
                    flag_nxt = cyc_rbit;
                    done_nxt = 1'h1;
                    st_nxt   = PS_IDLE;
                end
            end
            default: begin
                st_nxt   = PS_IDLE;
                wait_nxt = 1'h0;
            end
        endcase
        ready_nxt = (st_nxt == PS_IDLE);
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st_r    <= PS_IDLE;
            idx_r   <= 3'h0;
            wait_r  <= 1'h0;
            poll_r  <= 8'h00;
            ready_r <= 1'h1;
            done_r  <= 1'h0;
            grant_r <= 1'h0;
            flag_r  <= 1'h1;
        end else begin
            st_r    <= st_nxt;
            idx_r   <= idx_nxt;
            wait_r  <= wait_nxt;
            poll_r  <= poll_nxt;
            ready_r <= ready_nxt;
            done_r  <= done_nxt;
            grant_r <= grant_nxt;
            flag_r  <= flag_nxt;
        end
    end

    assign ready_o   = ready_r;
    assign done_o    = done_r;
    assign granted_o = grant_r;
    assign flag_o    = flag_r;

endmodule
`default_nettype wire

// ### dpsl_pkg.sv
// Package: constants and types for the semaphore port controller
package dpsl_pkg;

    // ------------------------------------------------------------
    // Clock and pin timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int SETUP_NS      = 5;
    localparam int STROBE_NS     = 25;
    localparam int RECOVER_NS    = 15;

    // Least times round up, never below one cycle
    function automatic int dpsl_ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int SETUP_CYC   = dpsl_ns_to_cyc(SETUP_NS);
    localparam int STROBE_CYC  = dpsl_ns_to_cyc(STROBE_NS);
    localparam int RECOVER_CYC = dpsl_ns_to_cyc(RECOVER_NS);
    localparam int SYNC_CYC    = 4;

    // ------------------------------------------------------------
    // Sizes and codes
    // ------------------------------------------------------------
    localparam int FLAG_COUNT = 8;
    localparam int INDEX_W    = 3;
    localparam int DATA_W     = 8;
    localparam int POLL_MAX   = 16;

    localparam logic FLAG_TAKE = 1'h0;
    localparam logic FLAG_FREE = 1'h1;

    localparam logic [INDEX_W-1:0] INDEX_LAST = 3'h7;

    typedef enum logic [1:0] {
        DPSL_OP_INIT    = 2'h0,
        DPSL_OP_ACQUIRE = 2'h1,
        DPSL_OP_RELEASE = 2'h2,
        DPSL_OP_READ    = 2'h3
    } dpsl_op_type;

    // Pin bundle toward one device port; data_oe high while driving
    typedef struct packed {
        logic               semaphore_select_n;
        logic               out_drive_enable_n;
        logic               read_write_n;
        logic [INDEX_W-1:0] flag_index_bits;
        logic [DATA_W-1:0]  data_out;
        logic               data_oe;
    } dpsl_pins_type;

    localparam dpsl_pins_type PINS_IDLE = '{
        semaphore_select_n: 1'h1,
        out_drive_enable_n: 1'h1,
        read_write_n:       1'h1,
        flag_index_bits:    3'h0,
        data_out:           8'h00,
        data_oe:            1'h0
    };

endpackage

// ### dpsl_pin_cycle.sv
// One semaphore pin access: setup, strobe, recovery
`timescale 1ns/100ps
`default_nettype none
module dpsl_pin_cycle
    import dpsl_pkg::*;
(
    input  wire logic                clock_i,
    input  wire logic                rst_i,
    input  wire logic                start_i,
    input  wire logic                write_i,
    input  wire logic [INDEX_W-1:0]  index_i,
    input  wire logic                wbit_i,
    input  wire logic [DATA_W-1:0]   data_i,
    output logic                     done_o,
    output logic                     rbit_o,
    output var dpsl_pins_type        pins_o
);

    // Read bit is taken one cycle after the last flop settles
    if (STROBE_CYC <= SYNC_CYC) begin : g_chk
        $error("Strobe too short for the input synchroniser");
    end

    typedef enum logic [3:0] {
        PC_IDLE    = 4'h1,
        PC_SETUP   = 4'h2,
        PC_STROBE  = 4'h4,
        PC_RECOVER = 4'h8
    } dpsl_pc_type;

    // ------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------
    logic [DATA_W-1:0] s1_r, s2_r, s3_r, agreed_r, agreed_nxt;

    always_comb begin
        agreed_nxt = agreed_r;
        if (s2_r == s3_r) begin
            agreed_nxt = s3_r;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s1_r     <= 8'h00;
            s2_r     <= 8'h00;
            s3_r     <= 8'h00;
            agreed_r <= 8'h00;
        end else begin
            s1_r     <= data_i;
            s2_r     <= s1_r;
            s3_r     <= s2_r;
            agreed_r <= agreed_nxt;
        end
    end

    // ------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------
    dpsl_pc_type   st_r, st_nxt;
    logic [4:0]    cnt_r, cnt_nxt;
    dpsl_pins_type pins_r, pins_nxt;
    logic          done_r, done_nxt;
    logic          rbit_r, rbit_nxt;

    always_comb begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        pins_nxt = pins_r;
        done_nxt = 1'h0;
        rbit_nxt = rbit_r;
        case (st_r)
            PC_IDLE: begin
                if (start_i) begin
                    pins_nxt.flag_index_bits = index_i;
                    pins_nxt.read_write_n    = ~write_i;
                    pins_nxt.data_out        = {DATA_W{wbit_i}};
                    pins_nxt.data_oe         = write_i;
                    cnt_nxt = 5'(SETUP_CYC - 1);
                    st_nxt  = PC_SETUP;
                end
            end
            PC_SETUP: begin
                if (cnt_r == 5'h00) begin
                    pins_nxt.semaphore_select_n = 1'h0;
                    pins_nxt.out_drive_enable_n = pins_r.read_write_n ? 1'h0
                                                                      : 1'h1;
                    cnt_nxt = 5'(STROBE_CYC - 1);
                    st_nxt  = PC_STROBE;
                end else begin
                    cnt_nxt = cnt_r - 5'h01;
                end
            end
            PC_STROBE: begin
                if (cnt_r == 5'h00) begin
                    // Flag is spread on all bits; bit 0 is enough
                    rbit_nxt = agreed_r[0];
                    pins_nxt.semaphore_select_n = 1'h1;
                    pins_nxt.out_drive_enable_n = 1'h1;
                    cnt_nxt = 5'(RECOVER_CYC - 1);
                    st_nxt  = PC_RECOVER;
                end else begin
                    cnt_nxt = cnt_r - 5'h01;
                end
            end
            PC_RECOVER: begin
                // Select stays high here so the next read re-latches
                pins_nxt.read_write_n = 1'h1;
                pins_nxt.data_oe      = 1'h0;
                if (cnt_r == 5'h00) begin
                    done_nxt = 1'h1;
                    st_nxt   = PC_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 5'h01;
                end
            end
            default: begin
                st_nxt   = PC_IDLE;
                pins_nxt = PINS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st_r   <= PC_IDLE;
            cnt_r  <= 5'h00;
            pins_r <= PINS_IDLE;
            done_r <= 1'h0;
            rbit_r <= 1'h1;
        end else begin
            st_r   <= st_nxt;
            cnt_r  <= cnt_nxt;
            pins_r <= pins_nxt;
            done_r <= done_nxt;
            rbit_r <= rbit_nxt;
        end
    end

    assign done_o = done_r;
    assign rbit_o = rbit_r;
    assign pins_o = pins_r;

endmodule
`default_nettype wire

// ### dpsl_port_props.sv
// Checker: pin and handshake properties of one semaphore port controller
`timescale 1ns/100ps
`default_nettype none
module dpsl_port_props
    import dpsl_pkg::*;
#(
    parameter int POLL_LIMIT = POLL_MAX
)
(
    input wire logic               clock_i,
    input wire logic               rst_i,
    input wire logic               cmd_valid_i,
    input wire dpsl_op_type        cmd_op_i,
    input wire logic [INDEX_W-1:0] cmd_index_i,
    input wire logic [DATA_W-1:0]  data_i,
    input wire logic               ready_o,
    input wire logic               done_o,
    input wire logic               granted_o,
    input wire logic               flag_o,
    input wire dpsl_pins_type      pins_o
);
    logic sel_n;
    logic oe_n;
    logic rw_n;
    assign sel_n = pins_o.semaphore_select_n;
    assign oe_n  = pins_o.out_drive_enable_n;
    assign rw_n  = pins_o.read_write_n;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence strobe_s;
        !sel_n [*5] ##1 sel_n;
    endsequence
    // Gap lets the device output latch capture afresh on every poll
    sequence gap_s;
        sel_n [*3];
    endsequence

    strobe_gap_a:
        assert property ($fell(sel_n) |-> strobe_s ##0 gap_s)
        else $error("select strobe or recovery gap wrong");
    read_shape_a:
        assert property (!oe_n |-> !sel_n && rw_n && !pins_o.data_oe)
        else $error("output enable outside a clean read");
    write_data_a:
        assert property (!sel_n && !rw_n |-> pins_o.data_oe &&
            (pins_o.data_out == 8'h00 || pins_o.data_out == 8'hFF))
        else $error("write data not a replicated flag");
    index_hold_a:
        assert property (!sel_n |-> $stable(pins_o.flag_index_bits))
        else $error("flag index moved during strobe");
    grant_flag_a:
        assert property ($rose(granted_o) |-> flag_o == FLAG_TAKE)
        else $error("grant without a zero read back");
    cmd_bound_a:
        assert property ($fell(ready_o) |-> !done_o ##[8:400] done_o)
        else $error("command did not finish in time");
    done_pulse_a:
        assert property (done_o |-> ready_o ##1 !done_o)
        else $error("done not a single pulse with ready");
    reset_idle_a:
        assert property ($fell(rst_i) |-> pins_o == PINS_IDLE && ready_o)
        else $error("pins not idle after reset");
endmodule

bind dpsl_port_ctrl dpsl_port_props #(.POLL_LIMIT(POLL_LIMIT)) i_props (
    .clock_i(clock_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
    .cmd_op_i(cmd_op_i), .cmd_index_i(cmd_index_i), .data_i(data_i),
    .ready_o(ready_o), .done_o(done_o), .granted_o(granted_o),
    .flag_o(flag_o), .pins_o(pins_o)
);
`default_nettype wire

// ### dpsl_sem_dev.sv
// Behavioural model of the two-port eight-flag semaphore unit
`timescale 1ns/100ps
`default_nettype none
module dpsl_sem_dev
    import dpsl_pkg::*;
(
    input  wire dpsl_pins_type pins_l_i,
    input  wire dpsl_pins_type pins_r_i,
    output logic [DATA_W-1:0]  data_l_o,
    output logic [DATA_W-1:0]  data_r_o
);
    dpsl_pins_type         pin   [2];
    logic [FLAG_COUNT-1:0] req_n [2];
    int                    owner [FLAG_COUNT]; // Minus one unknown, two free
    logic [DATA_W-1:0]     dout  [2];

    assign pin[0]   = pins_l_i;
    assign pin[1]   = pins_r_i;
    assign data_l_o = dout[0];
    assign data_r_o = dout[1];

    initial foreach (owner[i]) owner[i] = -1;

    // First write processed wins; equal times fall to either side
    task automatic sem_write(input int k, input logic [2:0] i, input logic v);
        req_n[k][i] = v;
        if (owner[i] < 0) begin
            if (req_n[0][i] === 1'h1 && req_n[1][i] === 1'h1) owner[i] = 2;
        end else if (owner[i] == k) begin
            if (v) owner[i] = (req_n[1-k][i] === 1'h0) ? 1 - k : 2;
        end else if (owner[i] == 2 && v == 1'h0) begin
            owner[i] = k;
        end
    endtask

    function automatic logic flag_of(input int k, input logic [2:0] i);
        if (owner[i] < 0) return 1'hx;
        return (owner[i] == k) ? FLAG_TAKE : FLAG_FREE;
    endfunction

    for (genvar k = 0; k < 2; k++) begin : g_side
        logic wstb;
        logic rstb;
        logic lat = 1'h0;
        assign wstb = pin[k].semaphore_select_n | pin[k].read_write_n;
        assign rstb = pin[k].semaphore_select_n | pin[k].out_drive_enable_n;
        always @(posedge wstb) begin
            if (pin[k].data_oe === 1'h1) begin
                sem_write(k, pin[k].flag_index_bits, pin[k].data_out[0]);
            end
        end
        // Latched at strobe start so a far-side write cannot tear it
        always @(negedge rstb) begin
            lat = flag_of(k, pin[k].flag_index_bits);
        end
        // Released lines show the inverse of the last value
        assign dout[k] = rstb ? ~{DATA_W{lat}} : {DATA_W{lat}};
    end
endmodule
`default_nettype wire

// ### tb_top.sv
// Testbench: two port controllers sharing one modelled semaphore unit
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import dpsl_pkg::*;
;
    localparam int POLL  = 3;
    localparam int LIMIT = 6000;

    logic          clock_i;
    logic          rst_i;
    logic [1:0]    valid;
    dpsl_op_type   op    [2];
    logic [2:0]    idx   [2];
    wire [1:0]     dn;
    wire [1:0]     gr;
    wire [1:0]     fl;
    dpsl_pins_type pins  [2];
    logic [7:0]    din   [2];
    logic [7:0]    mdout [2];
    int            n_fail = 0;
    int            total_checks = 0;
    int            cycles = 0;

    always #2.5 clock_i = ~clock_i;

    dpsl_sem_dev i_dev (.pins_l_i(pins[0]), .pins_r_i(pins[1]),
        .data_l_o(mdout[0]), .data_r_o(mdout[1]));

    for (genvar k = 0; k < 2; k++) begin : g_port
        assign din[k] = pins[k].data_oe ? pins[k].data_out : mdout[k];
        dpsl_port_ctrl #(.POLL_LIMIT(POLL)) i_dut (
            .clock_i(clock_i), .rst_i(rst_i), .cmd_valid_i(valid[k]),
            .cmd_op_i(op[k]), .cmd_index_i(idx[k]), .data_i(din[k]),
            .ready_o(), .done_o(dn[k]), .granted_o(gr[k]),
            .flag_o(fl[k]), .pins_o(pins[k])
        );
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic seen, input logic exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %b seen %b", what, exp, seen);
        end
    endtask

    // Called just after an edge; returns at the edge that sees done
    task automatic run(input int p, input dpsl_op_type o, input int i);
        valid[p] <= 1'h1;
        op[p]    <= o;
        idx[p]   <= i[2:0];
        @(posedge clock_i);
        valid[p] <= 1'h0;
        do @(posedge clock_i); while (dn[p] !== 1'h1);
    endtask

    task automatic s_init();
        fork
            run(0, DPSL_OP_INIT, 0);
            run(1, DPSL_OP_INIT, 0);
        join
        for (int i = 0; i < FLAG_COUNT; i++) begin
            for (int p = 0; p < 2; p++) begin
                run(p, DPSL_OP_READ, i);
                check("free after init", fl[p], FLAG_FREE);
            end
        end
    endtask

    task automatic s_take();
        run(0, DPSL_OP_ACQUIRE, 3);
        check("left granted", gr[0], 1'h1);
        check("left flag", fl[0], FLAG_TAKE);
        run(1, DPSL_OP_READ, 3);
        check("right sees held", fl[1], FLAG_FREE);
        run(1, DPSL_OP_ACQUIRE, 3);
        check("right refused", gr[1], 1'h0);
        check("right withdrew", i_dev.req_n[1][3], 1'h1);
        run(0, DPSL_OP_RELEASE, 3);
        check("left released", gr[0], 1'h0);
        run(1, DPSL_OP_ACQUIRE, 3);
        check("right takes free", gr[1], 1'h1);
        run(1, DPSL_OP_RELEASE, 3);
    endtask

    task automatic s_pass();
        run(0, DPSL_OP_ACQUIRE, 4);
        fork
            run(1, DPSL_OP_ACQUIRE, 4);
            begin
                repeat (14) @(posedge clock_i);
                run(0, DPSL_OP_RELEASE, 4);
            end
        join
        check("handed to right", gr[1], 1'h1);
        run(0, DPSL_OP_ACQUIRE, 4);
        check("left locked out", gr[0], 1'h0);
        run(1, DPSL_OP_RELEASE, 4);
        run(0, DPSL_OP_ACQUIRE, 4);
        check("left after handback", gr[0], 1'h1);
        run(0, DPSL_OP_RELEASE, 4);
    endtask

    task automatic s_race();
        int w;
        fork
            run(0, DPSL_OP_ACQUIRE, 5);
            run(1, DPSL_OP_ACQUIRE, 5);
        join
        check("one winner", gr[0] ^ gr[1], 1'h1);
        w = (gr[1] === 1'h1) ? 1 : 0;
        run(w, DPSL_OP_RELEASE, 5);
        run(1 - w, DPSL_OP_READ, 5);
        check("free after race", fl[1 - w], FLAG_FREE);
    endtask

    // Even flags to the left, odd to the right, then read by index
    task automatic s_split();
        for (int i = 0; i < FLAG_COUNT; i++) begin
            run(i % 2, DPSL_OP_ACQUIRE, i);
            check("owner granted", gr[i % 2], 1'h1);
        end
        for (int i = 0; i < FLAG_COUNT; i++) begin
            run(0, DPSL_OP_READ, i);
            check("left view by index", fl[0], i[0]);
            run(i % 2, DPSL_OP_RELEASE, i);
        end
    endtask

    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_fail++;
            $display("[ERR] run time expected %0d seen more", LIMIT);
            complete_run();
        end
    end

    initial begin
        clock_i = 1'h0;
        rst_i   = 1'h1;
        valid   = 2'h0;
        op[0]   = DPSL_OP_READ;
        op[1]   = DPSL_OP_READ;
        idx[0]  = 3'h0;
        idx[1]  = 3'h0;
        repeat (16) @(posedge clock_i);
        rst_i <= 1'h0;
        s_init();
        s_take();
        s_pass();
        s_race();
        s_split();
        complete_run();
    end
endmodule
`default_nettype wire
